// ### inc/rtg_defines.svh
// Constants for the relay thermal guard: thresholds and reset values.
// Assumes temperatures arrive as unsigned whole degrees Celsius, 8 bits.
// How it works
// - Fan turns on at 45 C
// - Fan turns off below 40 C
// - Trip at 75 C opens all channels
// - Trip drives active-low warning output low
// - Warning returns high below 59 C
// - Trip never notifies host
// - Tripped: commands ignored until power cycle
// - At power-up, 59 C or hotter trips
// - Eight channels switch independently otherwise
`ifndef RTG_DEFINES_SVH
`define RTG_DEFINES_SVH

//------------------------------------------------------------
// Temperature thresholds, degrees Celsius
//------------------------------------------------------------
`define RTG_FAN_ON_C      8'h2D
`define RTG_FAN_OFF_C     8'h28
`define RTG_TRIP_C        8'h4B
`define RTG_WARN_CLEAR_C  8'h3B

//------------------------------------------------------------
// Reset values
//------------------------------------------------------------
`define RTG_CHAN_RESET    8'h00
`define RTG_ONE           1'b1
`define RTG_ZERO          1'b0

`endif

// ### inc/rtg_pkg.sv
// Types shared by the thermal guard modules.
// Assumes the defines header is compiled alongside.
package rtg_pkg;
   //------------------------------------------------------------
   // Guard state machine
   //------------------------------------------------------------
   typedef enum logic [1:0] {
      RTG_POWERUP = 2'b00,   // First cycle after reset, checks temperature
      RTG_NORMAL  = 2'b01,   // Channel control follows host
      RTG_TRIPPED = 2'b10    // Locked out until power cycle
   } rtg_state_e;

   typedef logic [7:0] rtg_temp_t;
endpackage

// ### inc/rtg_temp_if.sv
// Carries the hotter sensor reading between guard modules.
// Assumes one clock domain shared by all users.
`timescale 1ns/1ps
interface rtg_temp_if;
   rtg_pkg::rtg_temp_t temp;      // Hottest sensor reading
   logic               fan_on;    // Fan demand
   modport src  (output temp, input  fan_on);
   modport fan  (input  temp, output fan_on);
endinterface

// ### src/rtg_fan_ctrl.sv
// Fan controller with hysteresis on the hottest reading.
// Assumes readings are synchronous to clk_in.
`timescale 1ns/1ps
`include "rtg_defines.svh"
module rtg_fan_ctrl (
   input  wire logic clk_in,   // Module clock
   input  wire logic rst_in,   // Synchronous reset, high
   input  wire logic ce_in,    // Clock enable
   rtg_temp_if.fan   tif       // Reading in, fan demand out
);
   logic fan;                  // Registered fan state

   //------------------------------------------------------------
   // Hysteresis
   //------------------------------------------------------------
   // Two thresholds stop the fan chattering around one value
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         fan <= `RTG_ZERO;
      end else if (ce_in) begin
         if (tif.temp >= `RTG_FAN_ON_C) begin
            fan <= `RTG_ONE;
         end else if (tif.temp < `RTG_FAN_OFF_C) begin
            fan <= `RTG_ZERO;
         end
      end
   end
   assign tif.fan_on = fan;

   a_fan_band_hold: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && tif.temp < `RTG_FAN_ON_C && tif.temp >= `RTG_FAN_OFF_C |=> $stable(fan))
      else $error("fan changed inside hysteresis band");
   a_fan_turn_on: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && tif.temp >= `RTG_FAN_ON_C |=> fan)
      else $error("fan not on at high threshold");
   a_fan_turn_off: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && tif.temp < `RTG_FAN_OFF_C |=> !fan)
      else $error("fan not off below low threshold");
endmodule

// ### src/rtg_guard.sv
// Top of the relay thermal guard: channel gating, trip, warning, fan.
// Assumes sensor readings and host commands are synchronous to clk_in,
// and that rst_in is asserted only by module power-on.
// Host commands that arrive during a lockout are dropped without any reply.
`timescale 1ns/1ps
`include "rtg_defines.svh"
module rtg_guard #(
   parameter int N_CHAN = 8                         // Relay channel count
) (
   input  wire logic              clk_in,          // Module clock, 200 MHz
   input  wire logic              rst_in,          // Power-on reset, sync, high
   input  wire logic              ce_in,           // Clock enable, freezes state
   input  wire logic [7:0]        temp_a_in,       // Sensor A, degrees C
   input  wire logic [7:0]        temp_b_in,       // Sensor B, degrees C
   input  wire logic [N_CHAN-1:0] chan_cmd_in,     // Host wanted channel states
   input  wire logic              chan_load_in,    // Host command strobe
   input  wire logic              mod_reset_in,    // Host module reset command
   output logic [N_CHAN-1:0]      relay_close_out, // Relay drive, 1 closes
   output logic                   warn_n_out,      // Warning, low when hot
   output logic                   fan_out,         // Fan drive
   output logic                   tripped_out      // Lockout active
);
   //------------------------------------------------------------
   // Declarations
   //------------------------------------------------------------
   rtg_pkg::rtg_state_e    state;      // Guard state
   rtg_pkg::rtg_state_e    next_state; // Next guard state
   rtg_pkg::rtg_temp_t     hot;        // Hotter of the two sensors
   logic [N_CHAN-1:0]      chan;       // Channel latch
   logic                   warn_n;     // Warning register
   rtg_temp_if             tif ();     // Link to fan controller
   logic                   trip_event; // Entering lockout this edge
   // All channels open, sized to the channel count rather than to eight
   localparam logic [N_CHAN-1:0] CHAN_OPEN = {N_CHAN{`RTG_ZERO}};

   // Worst case wins: either sensor may be nearer the hot relay
   assign hot = (temp_a_in > temp_b_in) ? temp_a_in : temp_b_in;
   assign tif.temp = hot;

   //------------------------------------------------------------
   // Decode helpers
   //------------------------------------------------------------
   // Host control is live only in the normal state; the latch, the
   // relay gate and the checks all ask the same question
   function automatic logic host_live(input rtg_pkg::rtg_state_e s);
      return (s == rtg_pkg::RTG_NORMAL);
   endfunction

   //------------------------------------------------------------
   // Fan controller
   //------------------------------------------------------------
   rtg_fan_ctrl u_fan (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .ce_in  (ce_in),
      .tif    (tif)
   );
   assign fan_out = tif.fan_on;

   //------------------------------------------------------------
   // Guard state machine
   //------------------------------------------------------------
   // Next state from temperature; tripped never leaves
   always_comb begin
      next_state = state;
      case (state)
         rtg_pkg::RTG_POWERUP: begin
            if (hot >= `RTG_WARN_CLEAR_C) begin
               // Still hot from before the power cycle
               next_state = rtg_pkg::RTG_TRIPPED;
            end else begin
               // Cool enough: hand control back to the host
               next_state = rtg_pkg::RTG_NORMAL;
            end
         end
         rtg_pkg::RTG_NORMAL: begin
            if (hot >= `RTG_TRIP_C) begin
               // Hotter sensor at trip level
               next_state = rtg_pkg::RTG_TRIPPED;
            end
         end
         rtg_pkg::RTG_TRIPPED: next_state = rtg_pkg::RTG_TRIPPED;
         // Unused code fails safe: treat it as a trip
         default:              next_state = rtg_pkg::RTG_TRIPPED;
      endcase
   end

   // State register
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state <= rtg_pkg::RTG_POWERUP;
      end else if (ce_in) begin
         state <= next_state;
      end
   end
   assign tripped_out = (state == rtg_pkg::RTG_TRIPPED);
   // Entry into lockout only; the warning set keys on this one edge
   assign trip_event = (next_state == rtg_pkg::RTG_TRIPPED) && (state != rtg_pkg::RTG_TRIPPED);

   //------------------------------------------------------------
   // Channel latch
   //------------------------------------------------------------
   // Host reset opens all; the host keeps its own copy and is never told
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         // Power-on: every relay starts open
         chan <= CHAN_OPEN;
      end else if (ce_in) begin
         if (next_state == rtg_pkg::RTG_TRIPPED || state == rtg_pkg::RTG_TRIPPED) begin
            chan <= CHAN_OPEN;
         // Host module reset opens every channel
         end else if (mod_reset_in) begin
            chan <= CHAN_OPEN;
         end else if (chan_load_in && host_live(state)) begin
            // One strobe may close or open any mix of channels
            chan <= chan_cmd_in;
         end
      end
   end

   always_comb begin
      // POWERUP and TRIPPED both hold every relay open
      for (int i = 0; i < N_CHAN; i++) begin
         relay_close_out[i] = chan[i] && host_live(state);
      end
   end

   //------------------------------------------------------------
   // Warning output
   //------------------------------------------------------------
   // Release is independent of the lockout: LED clears once cool
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         warn_n <= `RTG_ONE;
      end else if (ce_in) begin
         if (trip_event) begin
            // Set wins: a trip always pulls the line low
            warn_n <= `RTG_ZERO;
         end else if (hot < `RTG_WARN_CLEAR_C) begin
            warn_n <= `RTG_ONE;
         end
      end
   end
   assign warn_n_out = warn_n;

   //------------------------------------------------------------
   // Checks
   //------------------------------------------------------------
   // Every check stands down during power-on reset; that reset is
   // the power cycle, the only way out of a lockout

   a_trip_opens_all: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && host_live(state) && hot >= `RTG_TRIP_C |=> relay_close_out == CHAN_OPEN)
      else $error("relays not opened on trip");

   a_relay_follows: assert property (@(posedge clk_in) disable iff (rst_in)
      host_live(state) |-> relay_close_out == chan)
      else $error("relay drive differs from channel latch");

   a_trip_warn_low: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && host_live(state) && hot >= `RTG_TRIP_C |=> !warn_n_out)
      else $error("warning not low on trip");

   a_warn_quiet_normal: assert property (@(posedge clk_in) disable iff (rst_in)
      host_live(state) |-> warn_n_out)
      else $error("warning low without a trip");

   a_warn_release: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && !warn_n_out && hot < `RTG_WARN_CLEAR_C && state != rtg_pkg::RTG_POWERUP
      |=> warn_n_out)
      else $error("warning not released when cool");

   a_warn_holds_hot: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && !warn_n_out && hot >= `RTG_WARN_CLEAR_C |=> !warn_n_out)
      else $error("warning released while still hot");

   a_trip_local: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && host_live(state) && hot < `RTG_TRIP_C |=> !tripped_out)
      else $error("lockout entered below trip level");

   a_lockout_holds: assert property (@(posedge clk_in) disable iff (rst_in)
      tripped_out |=> tripped_out && relay_close_out == CHAN_OPEN)
      else $error("lockout left without power cycle");

   a_cmds_ignored: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && tripped_out && (chan_load_in || mod_reset_in) |=> chan == CHAN_OPEN)
      else $error("channel latch moved during lockout");

   a_powerup_retrip: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && state == rtg_pkg::RTG_POWERUP && hot >= `RTG_WARN_CLEAR_C |=> tripped_out)
      else $error("no retrip at power-up when hot");

   a_powerup_release: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && state == rtg_pkg::RTG_POWERUP && hot < `RTG_WARN_CLEAR_C |=> host_live(state))
      else $error("control not restored after cool power-up");

   a_chan_load: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && host_live(state) && next_state == rtg_pkg::RTG_NORMAL
      && chan_load_in && !mod_reset_in |=> relay_close_out == $past(chan_cmd_in))
      else $error("channel command not applied");

   a_host_reset_opens: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && mod_reset_in |=> chan == CHAN_OPEN)
      else $error("host reset left a channel closed");

   a_fan_trip_on: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && hot >= `RTG_TRIP_C |=> fan_out)
      else $error("fan off while at trip level");
endmodule

// ### tb/rtg_host_model.sv
// Host mainframe stand-in: sends channel commands, keeps its own record.
// Assumes the guard samples on rising clk_in; drives on falling edges.
`timescale 1ns/1ps
module rtg_host_model (
   input  wire logic  clk_in,       // Module clock
   input  wire logic  warn_n_in,    // Warning line from guard
   output logic [7:0] chan_cmd_out, // Wanted channel states
   output logic       load_out,     // Command strobe
   output logic       mreset_out,   // Module reset command
   output logic [7:0] record_out,   // Host stored channel state
   output logic       lamp_out      // External indicator lit
);
   //------------------------------------------------------------
   // Indicator and idle bus
   //------------------------------------------------------------
   assign lamp_out = !warn_n_in;
   initial begin
      chan_cmd_out = 8'h00;
      load_out = 1'b0;
      mreset_out = 1'b0;
      record_out = 8'h00;
   end
   // One command; data goes stale after the strobe so late sampling shows
   task send(input logic [7:0] v, input logic rst);
      @(negedge clk_in);
      chan_cmd_out = v;
      load_out = 1'b1;
      mreset_out = rst;
      record_out = rst ? 8'h00 : v;
      @(negedge clk_in);
      load_out = 1'b0;
      mreset_out = 1'b0;
      chan_cmd_out = ~v;
   endtask
endmodule

// ### tb/relay_thermal_guard_tb.sv
// Self-checking bench for the thermal guard top.
// Assumes the host model file is compiled first.
`timescale 1ns/1ps
module relay_thermal_guard_tb;
   logic       clk_in, rst_in, ce_in;   // Clock, power reset, enable
   logic [7:0] ta, tb_t;                // Sensor readings
   logic [7:0] cmd, rec, relay;         // Host command, record, relays
   logic       ld, mrst, lamp, warn_n, fan, trip;
   int         fails, n_compared;
   //------------------------------------------------------------
   // Clock, instances, watchdog
   //------------------------------------------------------------
   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end
   rtg_host_model host_u (.clk_in(clk_in), .warn_n_in(warn_n), .chan_cmd_out(cmd),
      .load_out(ld), .mreset_out(mrst), .record_out(rec), .lamp_out(lamp));
   rtg_guard #(.N_CHAN(8)) dut_u (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
      .temp_a_in(ta), .temp_b_in(tb_t), .chan_cmd_in(cmd), .chan_load_in(ld),
      .mod_reset_in(mrst), .relay_close_out(relay), .warn_n_out(warn_n),
      .fan_out(fan), .tripped_out(trip));
   // Whole run is under sixty cycles
   initial begin
      #20000;
      fails++;
      give_verdict();
   end
   //------------------------------------------------------------
   // Helpers
   //------------------------------------------------------------
   task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task heat(input logic [7:0] a, input logic [7:0] b);
      @(negedge clk_in);
      ta = a;
      tb_t = b;
      @(negedge clk_in);
   endtask
   // Power cycle with a given reading, one edge after release
   task power(input logic [7:0] t);
      @(negedge clk_in);
      rst_in = 1'b1;
      ta = t;
      tb_t = 8'h00;
      repeat (3) @(negedge clk_in);
      rst_in = 1'b0;
      @(negedge clk_in);
   endtask
   task give_verdict();
      $display("compared %0d failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   //------------------------------------------------------------
   // Scenarios
   //------------------------------------------------------------
   task t_loads();
      host_u.send(8'hA5, 1'b0);
      chk("relay", relay, 8'hA5);
      host_u.send(8'h5A, 1'b0);
      chk("relay", relay, 8'h5A);
      host_u.send(8'hFF, 1'b1);
      chk("relay", relay, 8'h00);
   endtask
   task t_fan();
      logic [7:0] t [6];
      logic       e [6];
      t = '{8'h2C, 8'h2D, 8'h29, 8'h28, 8'h27, 8'h2A};
      e = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
      // Alternate sensors so the hotter one always counts
      for (int i = 0; i < 6; i++) begin
         heat(i[0] ? t[i] : 8'h00, i[0] ? 8'h00 : t[i]);
         chk("fan", fan, e[i]);
      end
      // Frozen edges: a reading at the on threshold must not move the fan
      @(negedge clk_in);
      ce_in = 1'b0;
      heat(8'h2D, 8'h00);
      chk("fan", fan, 8'h00);
      @(negedge clk_in);
      ce_in = 1'b1;
      @(negedge clk_in);
      chk("fan", fan, 8'h01);
   endtask
   task t_trip();
      host_u.send(8'hFF, 1'b0);
      heat(8'h4A, 8'h00);
      chk("trip", trip, 8'h00);
      chk("relay", relay, 8'hFF);
      heat(8'h00, 8'h4B);
      chk("relay", relay, 8'h00);
      chk("warn", warn_n, 8'h00);
      chk("lamp", lamp, 8'h01);
      chk("record", rec, 8'hFF);
      host_u.send(8'h0F, 1'b0);
      host_u.send(8'h0F, 1'b1);
      chk("relay", relay, 8'h00);
      heat(8'h3B, 8'h00);
      chk("warn", warn_n, 8'h00);
      heat(8'h3A, 8'h00);
      chk("warn", warn_n, 8'h01);
      chk("trip", trip, 8'h01);
   endtask
   task t_repower();
      power(8'h3B);
      chk("trip", trip, 8'h01);
      @(negedge clk_in);
      chk("warn", warn_n, 8'h00);
      host_u.send(8'h81, 1'b0);
      chk("relay", relay, 8'h00);
      power(8'h3A);
      chk("trip", trip, 8'h00);
      host_u.send(8'h81, 1'b0);
      chk("relay", relay, 8'h81);
   endtask
   //------------------------------------------------------------
   // Main sequence
   //------------------------------------------------------------
   initial begin
      fails = 0;
      n_compared = 0;
      ce_in = 1'b1;
      rst_in = 1'b1;
      ta = 8'h14;
      tb_t = 8'h14;
      // Three reset edges at the start, then one edge out of power-up
      repeat (3) @(negedge clk_in);
      rst_in = 1'b0;
      @(negedge clk_in);
      chk("warn", warn_n, 8'h01);
      t_loads();
      t_fan();
      t_trip();
      t_repower();
      give_verdict();
   end
endmodule
